// File: src/oefr_defs.vh
// Purpose: Constants of the OTG event flag register block
// Assumes: Command codes on an 8-bit address, 16-bit data
// Notes: Times in ms, clock rate in kHz
`ifndef OEFR_DEFS_VH
`define OEFR_DEFS_VH

`define OEFR_RD_STATUS 8'h67
`define OEFR_RD_FLAGS 8'h68
`define OEFR_WR_FLAGS 8'hE8
`define OEFR_RD_ENABLE 8'h69
`define OEFR_WR_ENABLE 8'hE9
`define OEFR_RD_CONTROL 8'h6A
`define OEFR_WR_CONTROL 8'hEA

`define OEFR_FLAG_W 11
`define OEFR_FLAG_TIMER 10
`define OEFR_FLAG_SE0 9
`define OEFR_FLAG_SRP 8
`define OEFR_FLAG_RESUME 7
`define OEFR_FLAG_SUSPEND 6
`define OEFR_CTRL_SRP_SEL 9
`define OEFR_STAT_SE0 9

`define OEFR_FLAGS_RST 11'h000
`define OEFR_ENABLE_RST 11'h000
`define OEFR_SRP_SEL_RST 1'b0
`define OEFR_SYNC_RST 10'h005

`define OEFR_CLK_KHZ 100000
`define OEFR_SE0_TIME_MS 2
`define OEFR_IDLE_TIME_MS 3

`endif

// File: src/oefr_event_flags.v
// Purpose: OTG event flag register with enable mask and interrupt
// Assumes: One clock, pins are asynchronous and synchronised here
// Notes: Reads answer one cycle after the read strobe
`timescale 1ns/100ps
`include "oefr_defs.vh"

module oefr_event_flags #(
  parameter integer SE0_CYCLES = `OEFR_SE0_TIME_MS * `OEFR_CLK_KHZ,
  parameter integer IDLE_CYCLES = `OEFR_IDLE_TIME_MS * `OEFR_CLK_KHZ,
  parameter integer CNT_W = 20
) (
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  input wire [7:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdData,
  input wire timerExpired,
  input wire dpLevel,
  input wire dmLevel,
  input wire srpVbusPulse,
  input wire srpDataPulse,
  input wire remotePullupPresent,
  input wire bSessionValid,
  input wire aSessionValid,
  input wire bSessionOver,
  input wire aSupplyValid,
  input wire plugIdLevel,
  output wire otgIrq
);

  // ****************************************
  // Constants
  // ****************************************
  localparam [31:0] SE0_FULL = SE0_CYCLES;
  localparam [31:0] IDLE_FULL = IDLE_CYCLES;
  localparam [CNT_W-1:0] SE0_MAX = SE0_FULL[CNT_W-1:0];
  localparam [CNT_W-1:0] IDLE_MAX = IDLE_FULL[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

  // ****************************************
  // Pin synchroniser
  // ****************************************
  // Bits 5..0 line up with flag bits 5..0
  wire [9:0] pinRaw;
  reg [9:0] syncA_reg;
  reg [9:0] syncB_reg;
  reg [9:0] prev_reg;

  assign pinRaw = {srpDataPulse, srpVbusPulse, dmLevel, dpLevel,
                   remotePullupPresent, bSessionValid, aSessionValid,
                   bSessionOver, aSupplyValid, plugIdLevel};

  // Resets match the status reset, so no false change after reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_reg <= `OEFR_SYNC_RST;
      syncB_reg <= `OEFR_SYNC_RST;
      prev_reg <= `OEFR_SYNC_RST;
    end else if (clkEn) begin
      syncA_reg <= pinRaw;
      syncB_reg <= syncA_reg;
      prev_reg <= syncB_reg;
    end
  end

  wire [5:0] indNow;
  wire [5:0] indChange;
  wire lineDp;
  wire lineDm;
  wire lineSe0;
  wire lineJ;
  wire lineK;
  wire srpVbusRise;
  wire srpDataRise;

  assign indNow = syncB_reg[5:0];
  assign indChange = syncB_reg[5:0] ^ prev_reg[5:0];
  assign lineDp = syncB_reg[6];
  assign lineDm = syncB_reg[7];
  assign lineSe0 = !lineDp && !lineDm;
  assign lineJ = lineDp && !lineDm;
  assign lineK = !lineDp && lineDm;
  assign srpVbusRise = syncB_reg[8] && !prev_reg[8];
  assign srpDataRise = syncB_reg[9] && !prev_reg[9];

  // ****************************************
  // Registers
  // ****************************************
  reg [`OEFR_FLAG_W-1:0] flags_reg;
  reg [`OEFR_FLAG_W-1:0] flags_next;
  reg [`OEFR_FLAG_W-1:0] enable_reg;
  reg srpSel_reg;
  reg [CNT_W-1:0] se0Cnt_reg;
  reg se0State_reg;
  reg se0State_next;
  reg [CNT_W-1:0] idleCnt_reg;
  reg portState_reg;
  reg portState_next;
  reg lineWasJ_reg;

  // ****************************************
  // Long SE0 detector
  // ****************************************
  // Count saturates, so a stuck SE0 flags only once
  localparam [0:0] SE0_SHORT = 1'b0;
  localparam [0:0] SE0_LONG = 1'b1;
  wire se0Long;
  wire se0LongRise;
  assign se0Long = (se0State_reg == SE0_LONG);
  assign se0LongRise = lineSe0 && (se0Cnt_reg == SE0_MAX) && !se0Long;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      se0Cnt_reg <= CNT_ZERO;
    end else if (clkEn) begin
      if (!lineSe0) begin
        se0Cnt_reg <= CNT_ZERO;
      end else if (se0Cnt_reg != SE0_MAX) begin
        se0Cnt_reg <= se0Cnt_reg + CNT_ONE;
      end
    end
  end

  always @* begin
    se0State_next = se0State_reg;
    case (se0State_reg)
      SE0_SHORT: begin
        if (se0LongRise) begin
          se0State_next = SE0_LONG;
        end
      end
      SE0_LONG: begin
        if (!lineSe0) begin
          se0State_next = SE0_SHORT;
        end
      end
      default: begin
        se0State_next = SE0_SHORT;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      se0State_reg <= SE0_SHORT;
    end else if (clkEn) begin
      se0State_reg <= se0State_next;
    end
  end

  // ****************************************
  // Suspend and resume detector
  // ****************************************
  // Idle is the J state; any other state leaves suspend
  localparam [0:0] PORT_ACTIVE = 1'b0;
  localparam [0:0] PORT_SUSPENDED = 1'b1;
  wire portSuspended;
  wire suspendEnter;
  wire resumeSeen;
  assign portSuspended = (portState_reg == PORT_SUSPENDED);
  assign suspendEnter = lineJ && (idleCnt_reg == IDLE_MAX) && !portSuspended;
  assign resumeSeen = portSuspended && lineWasJ_reg && lineK;

  // Idle count saturates, so a long J enters suspend once
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idleCnt_reg <= CNT_ZERO;
      lineWasJ_reg <= 1'b0;
    end else if (clkEn) begin
      lineWasJ_reg <= lineJ;
      if (!lineJ) begin
        idleCnt_reg <= CNT_ZERO;
      end else if (idleCnt_reg != IDLE_MAX) begin
        idleCnt_reg <= idleCnt_reg + CNT_ONE;
      end
    end
  end

  always @* begin
    portState_next = portState_reg;
    case (portState_reg)
      PORT_ACTIVE: begin
        if (suspendEnter) begin
          portState_next = PORT_SUSPENDED;
        end
      end
      PORT_SUSPENDED: begin
        if (!lineJ) begin
          portState_next = PORT_ACTIVE;
        end
      end
      default: begin
        portState_next = PORT_ACTIVE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      portState_reg <= PORT_ACTIVE;
    end else if (clkEn) begin
      portState_reg <= portState_next;
    end
  end

  // ****************************************
  // Event collection
  // ****************************************
  reg [`OEFR_FLAG_W-1:0] setVec;
  reg [`OEFR_FLAG_W-1:0] clrVec;
  wire flagsWrite;
  wire enableWrite;
  wire controlWrite;
  assign flagsWrite = regWrite && (regAddr == `OEFR_WR_FLAGS);
  assign enableWrite = regWrite && (regAddr == `OEFR_WR_ENABLE);
  assign controlWrite = regWrite && (regAddr == `OEFR_WR_CONTROL);

  always @* begin
    setVec = `OEFR_FLAGS_RST;
    setVec[`OEFR_FLAG_TIMER] = timerExpired;
    setVec[`OEFR_FLAG_SE0] = se0LongRise;
    setVec[`OEFR_FLAG_SRP] = srpSel_reg ? srpDataRise : srpVbusRise;
    setVec[`OEFR_FLAG_RESUME] = resumeSeen;
    setVec[`OEFR_FLAG_SUSPEND] = suspendEnter;
    setVec[5] = indChange[5];
    setVec[4] = indChange[4];
    setVec[3] = indChange[3];
    setVec[2] = indChange[2];
    setVec[1] = indChange[1];
    setVec[0] = indChange[0];
  end

  always @* begin
    clrVec = `OEFR_FLAGS_RST;
    if (flagsWrite) begin
      clrVec = regWrData[`OEFR_FLAG_W-1:0];
    end
    // Set applied after clear so an event is never lost to a clear in the same cycle
    flags_next = (flags_reg & ~clrVec) | setVec;
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= `OEFR_FLAGS_RST;
      enable_reg <= `OEFR_ENABLE_RST;
      srpSel_reg <= `OEFR_SRP_SEL_RST;
    end else if (clkEn) begin
      flags_reg <= flags_next;
      if (enableWrite) begin
        enable_reg <= regWrData[`OEFR_FLAG_W-1:0];
      end
      if (controlWrite) begin
        srpSel_reg <= regWrData[`OEFR_CTRL_SRP_SEL];
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Reserved bits and unmapped codes read as zero
  reg [15:0] rdMux;

  always @* begin
    rdMux = 16'h0000;
    case (regAddr)
      `OEFR_RD_FLAGS: begin
        rdMux[`OEFR_FLAG_W-1:0] = flags_reg;
      end
      `OEFR_RD_ENABLE: begin
        rdMux[`OEFR_FLAG_W-1:0] = enable_reg;
      end
      `OEFR_RD_CONTROL: begin
        rdMux[`OEFR_CTRL_SRP_SEL] = srpSel_reg;
      end
      `OEFR_RD_STATUS: begin
        rdMux[`OEFR_STAT_SE0] = se0Long;
        rdMux[5:0] = indNow;
      end
      default: begin
        rdMux = 16'h0000;
      end
    endcase
  end

  // Data holds only in the cycle after the read strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 16'h0000;
    end else if (clkEn) begin
      if (regRead) begin
        regRdData <= rdMux;
      end else begin
        regRdData <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  // Level from registers only; no glitch from the bus
  assign otgIrq = |(flags_reg & enable_reg);

endmodule

// File: tb/oefr_flags_monitor.sv
// Purpose: Checker on the event flag block ports
// Assumes: One clock domain, clkEn mostly high
// Notes: Bit 10 stands in for all flags
`timescale 1ns/100ps
module oefr_flags_monitor (
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  input wire [7:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regRdData,
  input wire timerExpired,
  input wire otgIrq
);
  // ****
  // Assertions
  // ****
  wire rdF = clkEn && regRead && regAddr == 8'h68;
  wire wrF = clkEn && regWrite && regAddr == 8'hE8;
  wire wrE = clkEn && regWrite && regAddr == 8'hE9;
  wire tmr = clkEn && timerExpired;
  wire rdE = clkEn && regRead && regAddr == 8'h69;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rd_idle: assert property (clkEn && !regRead |=> regRdData == 16'h0000)
    else $error("read data not idle");
  a_timer_set: assert property (tmr ##1 rdF |=> regRdData[10])
    else $error("timer flag not set");
  a_set_wins: assert property (tmr && wrF && regWrData[10] ##1 rdF |=> regRdData[10])
    else $error("event lost to clear");
  a_one_clears: assert property (wrF && regWrData[10] && !tmr ##1 rdF |=> !regRdData[10])
    else $error("flag not cleared");
  a_zero_keeps: assert property (rdF ##1 (wrF && !regWrData[10] && regRdData[10]) ##1 rdF |=> regRdData[10])
    else $error("zero write cleared flag");
  a_mask_off: assert property (wrE && regWrData[10:0] == 11'h000 |=> !otgIrq)
    else $error("irq with all masked");
  a_irq_timer: assert property (wrE && regWrData[10] ##1 (tmr && !regWrite) |=> otgIrq)
    else $error("irq missing");
  a_enable_back: assert property (wrE ##1 rdE |=> regRdData == ($past(regWrData, 2) & 16'h07FF))
    else $error("enable readback wrong");
  c_irq: cover property (tmr ##1 otgIrq);
  c_set_wins: cover property (tmr && wrF);
  c_flags_rd: cover property (rdF ##1 regRdData != 16'h0000);
endmodule
bind oefr_event_flags oefr_flags_monitor mon (
  .clk(clk),
  .reset_n(reset_n),
  .clkEn(clkEn),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regRdData(regRdData),
  .timerExpired(timerExpired),
  .otgIrq(otgIrq)
);

// File: tb/oefr_remote_device.sv
// Purpose: Remote OTG device on the port
// Assumes: Tasks are called just after a clock edge
// Notes: Line parked in K so no idle timer runs early
`timescale 1ns/100ps
module oefr_remote_device (
  input wire clk,
  output reg dpLevel,
  output reg dmLevel,
  output reg srpVbusPulse,
  output reg srpDataPulse,
  output reg [5:0] indLevel
);
  initial begin
    dpLevel = 1'b0;
    dmLevel = 1'b1;
    srpVbusPulse = 1'b0;
    srpDataPulse = 1'b0;
    indLevel = 6'h05;
  end
  task setLine(input dp, input dm);
    begin
      dpLevel <= dp;
      dmLevel <= dm;
    end
  endtask
  task flipInd(input integer k);
    indLevel[k] <= ~indLevel[k];
  endtask
  // Session request by either method
  task srp(input dataWay);
    begin
      if (dataWay) srpDataPulse <= 1'b1;
      else srpVbusPulse <= 1'b1;
      repeat (3) @(posedge clk);
      srpDataPulse <= 1'b0;
      srpVbusPulse <= 1'b0;
    end
  endtask
endmodule

// File: tb/testbench.sv
// Purpose: Register level tests of the event flag block
// Assumes: Short SE0 and idle counts
// Notes: clkEn dropped once to check the freeze
`timescale 1ns/100ps
module testbench;
  reg clk = 1'b0;
  reg reset_n;
  reg clkEn;
  reg regWrite;
  reg regRead;
  reg timerExpired;
  reg [7:0] regAddr;
  reg [15:0] regWrData;
  wire [15:0] regRdData;
  wire dpLevel, dmLevel, srpVbusPulse, srpDataPulse, otgIrq;
  wire [5:0] indLevel;
  integer errCount = 0, checkCount = 0, cyc = 0, i;
  always #5 clk = ~clk;
  oefr_remote_device rdev (
    .clk(clk),
    .dpLevel(dpLevel),
    .dmLevel(dmLevel),
    .srpVbusPulse(srpVbusPulse),
    .srpDataPulse(srpDataPulse),
    .indLevel(indLevel)
  );
  oefr_event_flags #(
    .SE0_CYCLES(20),
    .IDLE_CYCLES(30),
    .CNT_W(20)
  ) dut (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .timerExpired(timerExpired),
    .dpLevel(dpLevel),
    .dmLevel(dmLevel),
    .srpVbusPulse(srpVbusPulse),
    .srpDataPulse(srpDataPulse),
    .remotePullupPresent(indLevel[5]),
    .bSessionValid(indLevel[4]),
    .aSessionValid(indLevel[3]),
    .bSessionOver(indLevel[2]),
    .aSupplyValid(indLevel[1]),
    .plugIdLevel(indLevel[0]),
    .otgIrq(otgIrq)
  );
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checkCount = checkCount + 1;
      if (seen !== exp) begin
        errCount = errCount + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task bus(input r, input w, input [7:0] a, input [15:0] d, input t);
    begin
      @(posedge clk);
      regRead <= r;
      regWrite <= w;
      regAddr <= a;
      regWrData <= d;
      timerExpired <= t;
    end
  endtask
  task idle(input integer n);
    repeat (n) bus(0, 0, 8'h00, 16'h0000, 0);
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      bus(1, 0, a, 16'h0000, 0);
      idle(1);
      #1 chk(regRdData, e);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    bus(0, 1, a, d, 0);
  endtask
  task printVerdict;
    begin
      if (errCount == 0 && checkCount > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Hang guard, far above the planned run
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      errCount = errCount + 1;
      printVerdict;
    end
  end
  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    timerExpired = 1'b0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h68, 16'h0000);
    rd(8'h70, 16'h0000);
    wr(8'hE9, 16'hFFFF);
    rd(8'h69, 16'h07FF);
    wr(8'hE9, 16'h0000);
    bus(0, 0, 8'h00, 16'h0000, 1);
    rd(8'h68, 16'h0400);
    chk({15'h0000, otgIrq}, 16'h0000);
    bus(1, 0, 8'h68, 16'h0000, 0);
    wr(8'hE8, 16'h0000);
    rd(8'h68, 16'h0400);
    wr(8'hE9, 16'h0400);
    bus(0, 0, 8'h00, 16'h0000, 1);
    rd(8'h68, 16'h0400);
    chk({15'h0000, otgIrq}, 16'h0001);
    bus(0, 1, 8'hE8, 16'h0400, 1);
    rd(8'h68, 16'h0400);
    wr(8'hE8, 16'hFFFF);
    rd(8'h68, 16'h0000);
    chk({15'h0000, otgIrq}, 16'h0000);
    // Frozen cycles drop a timer pulse and a write
    idle(1);
    clkEn <= 1'b0;
    bus(0, 0, 8'h00, 16'h0000, 1);
    wr(8'hE9, 16'h0000);
    idle(1);
    clkEn <= 1'b1;
    rd(8'h68, 16'h0000);
    rd(8'h69, 16'h0400);
    // Each indicator rises and falls once
    for (i = 0; i < 12; i = i + 1) begin
      idle(1);
      rdev.flipInd(i % 6);
      idle(4);
      rd(8'h68, 16'h0001 << (i % 6));
      wr(8'hE8, 16'hFFFF);
    end
    idle(1);
    rdev.srp(1);
    idle(4);
    rd(8'h68, 16'h0000);
    idle(1);
    rdev.srp(0);
    idle(4);
    rd(8'h68, 16'h0100);
    wr(8'hEA, 16'h0200);
    rd(8'h6A, 16'h0200);
    wr(8'hE8, 16'hFFFF);
    idle(1);
    rdev.srp(1);
    idle(4);
    rd(8'h68, 16'h0100);
    wr(8'hE8, 16'hFFFF);
    idle(1);
    rdev.setLine(0, 0);
    idle(15);
    rd(8'h68, 16'h0000);
    idle(10);
    rd(8'h68, 16'h0200);
    rd(8'h67, 16'h0205);
    wr(8'hE8, 16'hFFFF);
    idle(1);
    rdev.setLine(1, 0);
    idle(40);
    rd(8'h68, 16'h0040);
    wr(8'hE8, 16'hFFFF);
    idle(1);
    rdev.setLine(0, 1);
    idle(5);
    rd(8'h68, 16'h0080);
    // Mid-run reset wipes flags and enables
    wr(8'hE9, 16'h0080);
    idle(1);
    #1 chk({15'h0000, otgIrq}, 16'h0001);
    idle(1);
    reset_n <= 1'b0;
    idle(3);
    reset_n <= 1'b1;
    rd(8'h68, 16'h0000);
    rd(8'h69, 16'h0000);
    chk({15'h0000, otgIrq}, 16'h0000);
    printVerdict;
  end
endmodule
